// file: core/tegs_sequencer.sv
// Top of the three-emitter gesture sequencer with APB registers
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps

// Behaviour
// RULE1: Three emitter outputs exist, each lit separately by the measurement logic.
// RULE2: In normal proximity mode any single emitter can be chosen and only it is used.
// RULE3: A measurement with a given emitter lands in the result register of the same index.
// RULE4: Setting the gesture enable bit to one turns on handling across all three emitters.
// RULE5: With single-shot and gesture on, emitters are lit in turn and each result is stored apart.
// RULE6: The three-emitter run starts only on a trigger write while gesture and single-shot are set.
// RULE7: After the third result the gesture ready flag is set and, if unmasked, the interrupt fires.
// RULE8: Emitters run one, two, three in order and never two at once.
// RULE9: A new flag pulls the interrupt pin low; reading the flags clears them and the pin returns high.
// RULE10: In single-shot mode nothing is measured until a trigger write, one measurement per write.
// RULE11: With the logic output select set, the interrupt pin only shows near or far.
module tegs_sequencer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic afeValid,
  input wire logic [15:0] afeData,
  output logic sampleReq,
  output logic [2:0] emitters,
  output logic irq,
  output logic intN
);

  // Sequencer states; ISSUE gives the unit a clean one-cycle start
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    ISSUE = 3'b010,
    WAIT = 3'b100
  } tegs_seq_e;

  // All state but the reset synchroniser in one record: registers, sequencer and bus replies
  typedef struct packed {
    logic gestureEn;
    logic singleShot;
    logic proxEnable;
    logic [1:0] emitterSel;
    logic logicSel;
    logic trigPending;
    logic [1:0] status;
    logic [1:0] mask;
    logic [15:0] threshold;
    logic [2:0][15:0] results;
    tegs_seq_e state;
    logic [1:0] chan;
    logic gestRun;
    logic startPulse;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic intN;
  } tegs_top_s;

  tegs_top_s r_reg;
  tegs_top_s r_next;
  logic [1:0] rstSync_reg;
  logic rstN;
  logic unitDone;
  logic [15:0] unitResult;
  logic [2:0] unitEmitters;
  logic unitSampleReq;
  logic setupPhase;
  logic accessDone;
  logic isNear;
  logic trigWrite;

  // Unmasked flags; one term feeds both the level output and the pin
  function automatic logic flagsUp(input logic [1:0] flags, input logic [1:0] enables);
    flagsUp = |(flags & enables);
  endfunction

  // ==========================================================
  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync_reg <= 2'b00;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end

  assign rstN = rstSync_reg[1];

  // ==========================================================
  // Emitter pulse and sample unit
  tegs_emitter_unit u_emitter (
    .clk(clk),
    .rstN(rstN),
    .start(r_reg.startPulse),
    .channel(r_reg.chan),
    .afeValid(afeValid),
    .afeData(afeData),
    .emitters(unitEmitters),
    .sampleReq(unitSampleReq),
    .done(unitDone),
    .result(unitResult)
  );

  // Emitter pins and sample request come straight from the unit's flip-flops
  assign emitters = unitEmitters;
  assign sampleReq = unitSampleReq;

  // APB phases: read data is fetched in setup, effects land at access end
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && r_reg.pready;
  assign isNear = r_reg.results[r_reg.chan] > r_reg.threshold;
  // A trigger written in the cycle the sequencer consumes the last one is kept, set wins
  assign trigWrite = accessDone && !r_reg.pslverr && pwrite && (paddr == tegs_pkg::CTRL_OFF) &&
                     pwdata[tegs_pkg::SINGLE_SHOT_TRIGGER_BIT] && pwdata[tegs_pkg::SINGLE_SHOT_SELECT_BIT];

  // ==========================================================
  // Register file, sequencer and interrupt
  always_comb begin
    r_next = r_reg;
    r_next.startPulse = 1'b0;

    // Setup cycle: decode, capture read data, answer next cycle
    if (setupPhase) begin
      r_next.pready = 1'b1;
      r_next.pslverr = 1'b0;
      r_next.prdata = 32'h0000_0000;
      // Unmapped offsets answer with an error and zero data
      unique case (paddr)
        tegs_pkg::CTRL_OFF: begin
          r_next.prdata[tegs_pkg::GESTURE_EN_BIT] = r_reg.gestureEn;
          r_next.prdata[tegs_pkg::SINGLE_SHOT_SELECT_BIT] = r_reg.singleShot;
          r_next.prdata[tegs_pkg::SINGLE_SHOT_TRIGGER_BIT] = r_reg.trigPending;
          r_next.prdata[tegs_pkg::PROX_ENABLE_BIT] = r_reg.proxEnable;
          r_next.prdata[tegs_pkg::EMITTER_SEL_LSB +: 2] = r_reg.emitterSel;
          r_next.prdata[tegs_pkg::LOGIC_OUTPUT_SELECT_BIT] = r_reg.logicSel;
        end
        tegs_pkg::STATUS_OFF: begin
          r_next.prdata[tegs_pkg::FLAG_COUNT-1:0] = r_reg.status;
        end
        tegs_pkg::MASK_OFF: begin
          r_next.prdata[tegs_pkg::FLAG_COUNT-1:0] = r_reg.mask;
        end
        tegs_pkg::RESULT_ONE_OFF: begin
          r_next.prdata[15:0] = r_reg.results[0];
        end
        tegs_pkg::RESULT_TWO_OFF: begin
          r_next.prdata[15:0] = r_reg.results[1];
        end
        tegs_pkg::RESULT_THREE_OFF: begin
          r_next.prdata[15:0] = r_reg.results[2];
        end
        tegs_pkg::THRESHOLD_OFF: begin
          r_next.prdata[15:0] = r_reg.threshold;
        end
        default: begin
          r_next.pslverr = 1'b1;
        end
      endcase
    end else if (accessDone) begin
      r_next.pready = 1'b0;
      r_next.pslverr = 1'b0;
    end

    // Access end: writes and read side effects
    if (accessDone && !r_reg.pslverr) begin
      if (pwrite) begin
        unique case (paddr)
          tegs_pkg::CTRL_OFF: begin
            r_next.gestureEn = pwdata[tegs_pkg::GESTURE_EN_BIT]; // RULE4
            r_next.singleShot = pwdata[tegs_pkg::SINGLE_SHOT_SELECT_BIT];
            r_next.proxEnable = pwdata[tegs_pkg::PROX_ENABLE_BIT];
            r_next.emitterSel = pwdata[tegs_pkg::EMITTER_SEL_LSB +: 2]; // RULE2
            r_next.logicSel = pwdata[tegs_pkg::LOGIC_OUTPUT_SELECT_BIT];
            // A pending trigger dies with single-shot, so a later re-enable cannot start a stale run
            if (!pwdata[tegs_pkg::SINGLE_SHOT_SELECT_BIT]) begin
              r_next.trigPending = 1'b0;
            end else if (trigWrite) begin
              r_next.trigPending = 1'b1; // RULE10
            end
          end
          tegs_pkg::STATUS_OFF: begin
            // Write one to clear; a flag raised in this cycle still sets below
            r_next.status = r_reg.status & ~pwdata[tegs_pkg::FLAG_COUNT-1:0];
          end
          tegs_pkg::MASK_OFF: begin
            r_next.mask = pwdata[tegs_pkg::FLAG_COUNT-1:0];
          end
          tegs_pkg::THRESHOLD_OFF: begin
            r_next.threshold = pwdata[15:0];
          end
          default: begin
            r_next.threshold = r_reg.threshold;
          end
        endcase
      end else if (paddr == tegs_pkg::STATUS_OFF) begin
        // Clear only what was shown, so a flag set meanwhile survives
        r_next.status = r_reg.status & ~r_reg.prdata[tegs_pkg::FLAG_COUNT-1:0]; // RULE9
      end
    end

    // Measurement sequencer
    unique case (r_reg.state)
      // Single-shot waits for a trigger; continuous mode re-arms by itself
      IDLE: begin
        if (r_reg.singleShot && r_reg.trigPending) begin
          r_next.trigPending = trigWrite; // RULE10
          r_next.state = ISSUE;
          if (r_reg.gestureEn) begin
            r_next.gestRun = 1'b1; // RULE6
            r_next.chan = 2'h0; // RULE8
          end else begin
            r_next.gestRun = 1'b0;
            r_next.chan = tegs_pkg::tegs_chan(r_reg.emitterSel); // RULE2
          end
        end else if (!r_reg.singleShot && r_reg.proxEnable) begin
          // Continuous normal mode with the chosen emitter only
          r_next.gestRun = 1'b0;
          r_next.chan = tegs_pkg::tegs_chan(r_reg.emitterSel); // RULE2
          r_next.state = ISSUE;
        end
      end
      // One cycle pause so the unit starts on a settled channel
      ISSUE: begin
        r_next.startPulse = 1'b1;
        r_next.state = WAIT;
      end
      // Gesture steps one, two, three; a single measurement stops after one
      WAIT: begin
        if (unitDone) begin
          r_next.results[r_reg.chan] = unitResult; // RULE3
          if (r_reg.gestRun && (r_reg.chan != 2'h2)) begin
            r_next.chan = r_reg.chan + 2'h1; // RULE5
            r_next.state = ISSUE;
          end else begin
            r_next.state = IDLE;
            if (r_reg.gestRun) begin
              r_next.status[tegs_pkg::GESTURE_READY_BIT] = 1'b1; // RULE7
              r_next.gestRun = 1'b0;
            end else begin
              r_next.status[tegs_pkg::PROX_READY_BIT] = 1'b1;
            end
          end
        end
      end
      default: begin
        r_next.state = IDLE;
      end
    endcase

    // Level interrupt from unmasked flags, one cycle behind status
    r_next.irq = flagsUp(r_reg.status, r_reg.mask); // RULE7
    // Pin is either the active-low interrupt or the near/far output
    if (r_reg.logicSel) begin
      r_next.intN = !isNear; // RULE11
    end else begin
      r_next.intN = !flagsUp(r_reg.status, r_reg.mask); // RULE9
    end
  end

  // State register; only the synchronised reset clears it
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      r_reg <= '{
        gestureEn: 1'b0,
        singleShot: 1'b0,
        proxEnable: 1'b0,
        emitterSel: 2'h0,
        logicSel: 1'b0,
        trigPending: 1'b0,
        status: 2'h0,
        mask: tegs_pkg::MASK_RESET,
        threshold: tegs_pkg::THRESHOLD_RESET,
        results: '0,
        state: IDLE,
        chan: 2'h0,
        gestRun: 1'b0,
        startPulse: 1'b0,
        prdata: 32'h0000_0000,
        pready: 1'b0,
        pslverr: 1'b0,
        irq: 1'b0,
        // Pin idles high, no interrupt
        intN: 1'b1
      };
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign irq = r_reg.irq;
  assign intN = r_reg.intN;

endmodule

// file: core/tegs_pkg.sv
// Shared constants and types of the three-emitter gesture sequencer
package tegs_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] MASK_OFF = 8'h08;
  localparam logic [7:0] RESULT_ONE_OFF = 8'h0C;
  localparam logic [7:0] RESULT_TWO_OFF = 8'h10;
  localparam logic [7:0] RESULT_THREE_OFF = 8'h14;
  localparam logic [7:0] THRESHOLD_OFF = 8'h18;

  // ==========================================================
  // Control fields
  localparam int GESTURE_EN_BIT = 0;
  localparam int SINGLE_SHOT_SELECT_BIT = 1;
  localparam int SINGLE_SHOT_TRIGGER_BIT = 2;
  localparam int PROX_ENABLE_BIT = 3;
  localparam int EMITTER_SEL_LSB = 4;
  localparam int LOGIC_OUTPUT_SELECT_BIT = 6;

  // ==========================================================
  // Status and mask fields
  localparam int GESTURE_READY_BIT = 0;
  localparam int PROX_READY_BIT = 1;
  localparam int FLAG_COUNT = 2;

  // ==========================================================
  // Reset values
  localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // ==========================================================
  // Timing: emitter settle before sampling
  localparam int EMITTER_SETTLE_NS = 800;
  localparam int CLK_PERIOD_NS = 8;
  localparam int EMITTER_SETTLE_CYCLES = (EMITTER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESULT_WIDTH = 16;

  // ==========================================================
  // Channel select; code 3 is folded onto emitter three
  function automatic logic [1:0] tegs_chan(input logic [1:0] sel);
    tegs_chan = (sel == 2'h3) ? 2'h2 : sel;
  endfunction

endpackage

// file: core/tegs_emitter_unit.sv
// One emitter pulse and proximity sample per start request
`timescale 1ns/10ps
module tegs_emitter_unit (
  input wire logic clk,
  input wire logic rstN,
  input wire logic start,
  input wire logic [1:0] channel,
  input wire logic afeValid,
  input wire logic [15:0] afeData,
  output logic [2:0] emitters,
  output logic sampleReq,
  output logic done,
  output logic [15:0] result
);

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    SETTLE = 3'b010,
    SAMPLE = 3'b100
  } tegs_unit_e;

  typedef struct packed {
    tegs_unit_e state;
    logic [11:0] count;
    logic [2:0] emitters;
    logic sampleReq;
    logic done;
    logic [15:0] result;
  } tegs_unit_s;

  tegs_unit_s u_reg;
  tegs_unit_s u_next;

  // Emitter on, settle, sample, emitter off
  always_comb begin
    u_next = u_reg;
    u_next.done = 1'b0;
    unique case (u_reg.state)
      IDLE: begin
        if (start) begin
          u_next.state = SETTLE;
          u_next.count = 12'(tegs_pkg::EMITTER_SETTLE_CYCLES - 1);
          u_next.emitters = 3'b001 << channel; // RULE1
        end
      end
      SETTLE: begin
        if (u_reg.count == 12'h000) begin
          u_next.state = SAMPLE;
          u_next.sampleReq = 1'b1;
        end else begin
          u_next.count = u_reg.count - 12'h001;
        end
      end
      SAMPLE: begin
        // Emitter stays lit until the front end answers
        if (afeValid) begin
          u_next.state = IDLE;
          u_next.sampleReq = 1'b0;
          u_next.emitters = 3'b000; // RULE8
          u_next.result = afeData;
          u_next.done = 1'b1;
        end
      end
      default: begin
        u_next.state = IDLE;
        u_next.emitters = 3'b000;
        u_next.sampleReq = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      u_reg <= '{state: IDLE, count: 12'h000, emitters: 3'b000, sampleReq: 1'b0, done: 1'b0,
                 result: 16'h0000};
    end else begin
      u_reg <= u_next;
    end
  end

  assign emitters = u_reg.emitters;
  assign sampleReq = u_reg.sampleReq;
  assign done = u_reg.done;
  assign result = u_reg.result;

endmodule

// file: testbench/tegs_sequencer_sva.sv
// Port checker for the gesture sequencer, bound to its top
`timescale 1ns/10ps
module tegs_sequencer_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic afeValid,
  input wire logic [15:0] afeData,
  input wire logic sampleReq,
  input wire logic [2:0] emitters,
  input wire logic irq,
  input wire logic intN
);
  // ==========================================
  // Lit time counter, saturates so long stalls do not wrap
  logic [7:0] litCnt_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) litCnt_reg <= 8'h00;
    else if (emitters == 3'h0) litCnt_reg <= 8'h00;
    else if (litCnt_reg != 8'hFF) litCnt_reg <= litCnt_reg + 8'h01;
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence sSetup;
    psel && !penable;
  endsequence
  sequence sLitWait;
    (emitters != 3'h0) && !afeValid;
  endsequence
  a_emit_onehot: assert property ($onehot0(emitters)) else $error("two emitters lit");
  a_ready_next: assert property (sSetup |=> pready) else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error reply");
  a_unmapped_err: assert property (sSetup ##0 (paddr > tegs_pkg::THRESHOLD_OFF) |=> pslverr)
    else $error("unmapped address accepted");
  a_emit_hold: assert property (sLitWait |=> $stable(emitters)) else $error("emitter dropped early");
  a_emit_off: assert property ((emitters != 3'h0) && afeValid |=> emitters == 3'h0)
    else $error("emitters overlap");
  a_req_lit: assert property (sampleReq |-> emitters != 3'h0) else $error("sample with no emitter");
  a_req_hold: assert property (sampleReq && !afeValid |=> sampleReq) else $error("request withdrawn");
  a_settle_time: assert property ($rose(sampleReq) |-> int'(litCnt_reg) >= tegs_pkg::EMITTER_SETTLE_CYCLES)
    else $error("sampled before settle");
  c_third: cover property (emitters == 3'h4 && afeValid);
endmodule

bind tegs_sequencer tegs_sequencer_sva u_sva (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .afeValid(afeValid), .afeData(afeData), .sampleReq(sampleReq), .emitters(emitters), .irq(irq), .intN(intN));

// file: testbench/tegs_afe_model.sv
// Proximity front end model answering sample requests
`timescale 1ns/10ps
module tegs_afe_model (
  input wire logic clk,
  input wire logic sampleReq,
  input wire logic [2:0] emitters,
  input wire logic [7:0] lag,
  output logic afeValid,
  output logic [15:0] afeData
);
  logic [7:0] cnt;
  logic served;
  initial begin
    afeValid = 1'b0;
    afeData = 16'h5A5A;
    cnt = 8'h00;
    served = 1'b0;
  end
  // One answer per request after lag cycles; data names the lit emitter so misrouting shows
  always @(posedge clk) begin
    afeValid <= 1'b0;
    afeData <= ~afeData; // Stale data never looks valid
    if (!sampleReq) begin
      cnt <= 8'h00;
      served <= 1'b0;
    end else if (!served && cnt >= lag) begin
      afeValid <= 1'b1;
      afeData <= {8'hA5, 5'h00, emitters};
      served <= 1'b1;
    end else cnt <= cnt + 8'h01;
  end
endmodule

// file: testbench/tegs_sequencer_tb.sv
// Self-checking bench of the gesture sequencer
`timescale 1ns/10ps
module tegs_sequencer_tb;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} tegs_row_s;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, afeValid, sampleReq, irq, intN, qErr;
  logic [7:0] paddr, lag;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] afeData;
  logic [2:0] emitters, seen;
  int n_fail, samples_checked, i, j;
  tegs_row_s rows[11] = '{'{0, 8'h00, 0, 0}, '{0, 8'h04, 0, 0}, '{0, 8'h08, 0, 0}, '{0, 8'h0C, 0, 0},
    '{0, 8'h10, 0, 0}, '{0, 8'h14, 0, 0}, '{0, 8'h18, 0, 0}, '{1, 8'h18, 32'hFFFF_BEEF, 32'h0000_BEEF},
    '{1, 8'h08, 3, 3}, '{1, 8'h08, 0, 0}, '{1, 8'h18, 0, 0}};
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  tegs_sequencer u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .afeValid(afeValid),
    .afeData(afeData), .sampleReq(sampleReq), .emitters(emitters), .irq(irq), .intN(intN));
  tegs_afe_model u_afe (.clk(clk), .sampleReq(sampleReq), .emitters(emitters), .lag(lag),
    .afeValid(afeValid), .afeData(afeData));
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task results;
    $display("checked %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bus cycle; the request stands until ready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      chk(0, 1, "bus timeout");
      results;
    end
    q = prdata;
    qErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for one emitter pulse, bounded, and checks which one lit
  task waitLit(input logic [2:0] e);
    int k;
    k = 0;
    while (emitters === 3'h0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk(32'(emitters), 32'(e), "emitter lit");
    while (emitters !== 3'h0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) begin
      chk(0, 1, "emitter timeout");
      results;
    end
  endtask
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    lag = 8'h00;
    n_fail = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk({26'h0, emitters, sampleReq, irq, intN}, 32'h0000_0001, "idle outputs");
    for (i = 0; i < 11; i++) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(q, rows[i].e, "register row");
    end
    $display("register table done");
    // Single emitter selection; code 3 folds onto emitter three
    for (i = 0; i < 4; i++) begin
      j = (i == 3) ? 2 : i;
      apb(1'b1, tegs_pkg::CTRL_OFF, 32'h0000_0006 | (32'(i) << 4));
      waitLit(3'(1 << j));
      apb(1'b0, tegs_pkg::RESULT_ONE_OFF + 8'(4 * j), 32'h0);
      chk(q, 32'h0000_A500 | (32'h1 << j), "single result");
    end
    apb(1'b0, tegs_pkg::STATUS_OFF, 32'h0);
    $display("single emitter done");
    // Gesture run against a slow front end
    lag <= 8'd20;
    apb(1'b1, tegs_pkg::MASK_OFF, 32'h0000_0001);
    apb(1'b1, tegs_pkg::CTRL_OFF, 32'h0000_0007);
    waitLit(3'h1);
    waitLit(3'h2);
    waitLit(3'h4);
    repeat (3) @(posedge clk);
    chk({30'h0, irq, intN}, 32'h0000_0002, "gesture interrupt");
    for (i = 0; i < 3; i++) begin
      apb(1'b0, tegs_pkg::RESULT_ONE_OFF + 8'(4 * i), 32'h0);
      chk(q, 32'h0000_A500 | (32'h1 << i), "gesture result");
    end
    apb(1'b0, tegs_pkg::STATUS_OFF, 32'h0);
    chk(q & 32'h1, 32'h1, "ready flag");
    repeat (3) @(posedge clk);
    chk({30'h0, irq, intN}, 32'h0000_0001, "flag read clears");
    $display("gesture run done");
    // Trigger without single-shot must not start anything
    seen = 3'h0;
    apb(1'b1, tegs_pkg::CTRL_OFF, 32'h0000_0005);
    repeat (300) begin
      @(posedge clk);
      seen = seen | emitters;
    end
    chk(32'(seen), 32'h0, "no start");
    // Pin as near or far output
    apb(1'b1, tegs_pkg::CTRL_OFF, 32'h0000_0040);
    repeat (3) @(posedge clk);
    chk(32'(intN), 32'h0, "near output");
    apb(1'b1, tegs_pkg::THRESHOLD_OFF, 32'h0000_FFFF);
    repeat (3) @(posedge clk);
    chk(32'(intN), 32'h1, "far output");
    apb(1'b0, 8'h40, 32'h0);
    chk({q[30:0], qErr}, 32'h0000_0001, "unmapped read");
    // Continuous mode on emitter two, its flag interrupt, then a reset while lit
    apb(1'b1, tegs_pkg::MASK_OFF, 32'h0000_0002);
    apb(1'b1, tegs_pkg::CTRL_OFF, 32'h0000_0018);
    waitLit(3'h2);
    repeat (3) @(posedge clk);
    chk({30'h0, irq, intN}, 32'h0000_0002, "proximity interrupt");
    apb(1'b1, tegs_pkg::STATUS_OFF, 32'h0000_0002);
    repeat (3) @(posedge clk);
    chk({30'h0, irq, intN}, 32'h0000_0001, "write one clears");
    waitLit(3'h2);
    apb(1'b0, tegs_pkg::STATUS_OFF, 32'h0);
    chk(q, 32'h0000_0002, "proximity flag");
    j = 0;
    while (emitters === 3'h0 && j < 3000) begin
      @(posedge clk);
      j++;
    end
    chk(32'(emitters), 32'h0000_0002, "lit before reset");
    nrst <= 1'b0;
    @(posedge clk);
    chk({26'h0, emitters, sampleReq, irq, intN}, 32'h0000_0001, "reset mid run");
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, tegs_pkg::CTRL_OFF, 32'h0);
    chk(q, 32'h0000_0000, "control after reset");
    apb(1'b0, tegs_pkg::RESULT_TWO_OFF, 32'h0);
    chk(q, 32'h0000_0000, "result after reset");
    $display("continuous and reset done");
    $display("awkward cases done");
    results;
  end
endmodule
